// File: ddrx_cfg_init.sv
// Device-side configuration registers, init sequence tracker and latency timing
//
// Behaviour
// R1: Driver calibration may only hold its default or cleared value; others flag.
// R2: Posted delay field selects zero to six cycles of posted delay.
// R3: Early READ/WRITE is held for the posted delay, then issued internally.
// R4: First read data follows the command by posted plus column access delay.
// R5: Write data is expected one cycle before the read delay.
// R6: Reserved posted delay encodings must not be programmed by the controller.
// R7: Second register holds only the refresh-rate bit; set above 85C when needed.
// R8: Loads only with all banks idle, then the load gap before another command; bank state is not tracked, only the gap is checked.
// R9: Each configuration register keeps its value until reloaded.
// R10: Bits above twelve and bank_sel_two must be zero on a load.
// R11: Third extended register is loaded with all zeros.
// R12: Clock gate stays high once raised during initialization.
// R13: Only NOP or DESELECT for 200us, then clock gate rises.
// R14: At least 400ns after clock gate rises, then PRECHARGE ALL.
// R15: Then load the second register, bank_sel1 high, bank_sel0 low.
// R16: Then load the third register with both bank selects high.
// R17: Then load the first register with dll_disable_bit low to enable the loop.
// R18: Base load with dll_reset_bit high resets the loop; 200 cycles to lock.
// R19: Termination control stays low during power-up.
// R20: After loop reset: PRECHARGE ALL, then two or more REFRESH.
// R21: Then base load with dll_reset_bit low programs operating parameters.
// R22: First register calibration bits all ones, then a load clearing them.
// R23: Device ready 200 cycles after the loop reset load.
// R24: Time waits are converted to cycles rounding up.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/100ps
module ddrx_cfg_init
    import ddrx_pkg::*;
#(
    parameter int POWER_WAIT = POWER_WAIT_CYC
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // Command pins from the memory controller
    input  wire logic              clkGate,
    input  wire logic              chipSel_n,
    input  wire logic              rowStrobe_n,
    input  wire logic              colStrobe_n,
    input  wire logic              writeEn_n,
    input  wire logic              bank_sel0,
    input  wire logic              bank_sel1,
    input  wire logic              bank_sel_two,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              termination_ctrl_in,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // Device status and data timing
    output logic                   deviceReady,
    output logic                   refreshFast,
    output logic                   internalIssue,
    output logic                   internalIsWrite,
    output logic                   readDataStart,
    output logic                   writeDataExpect
);
    // Command decode
    ddrx_cmd_t   cmd;
    logic [1:0]  bankSel;
    logic        isLoad;
    logic        isPreAll;
    logic        notNop;
    logic [2:0]  calField;

    always_comb begin
        unique case ({chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n})
            4'b0000: cmd = CMD_LOAD;
            4'b0001: cmd = CMD_REFRESH;
            4'b0010: cmd = CMD_PRECHARGE;
            4'b0011: cmd = CMD_ACTIVATE;
            4'b0100: cmd = CMD_WRITE;
            4'b0101: cmd = CMD_READ;
            default: cmd = CMD_NOP;
        endcase
    end

    assign bankSel  = {bank_sel1, bank_sel0};
    assign isLoad   = (cmd == CMD_LOAD);
    assign isPreAll = (cmd == CMD_PRECHARGE) && addr[PRE_ALL_POS];
    assign notNop   = (cmd != CMD_NOP);
    assign calField = addr[CAL_HI:CAL_LO];

    // Configuration register storage
    logic [ADDR_W-1:0] baseCfg_r;
    logic [ADDR_W-1:0] extOne_r;
    logic [ADDR_W-1:0] extTwo_r;
    logic [ADDR_W-1:0] extThree_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            baseCfg_r  <= CFG_RESET;
            extOne_r   <= CFG_RESET;
            extTwo_r   <= CFG_RESET;
            extThree_r <= CFG_RESET;
        end else if (isLoad) begin // [R9]
            unique case (bankSel)
                SEL_BASE:  baseCfg_r  <= addr;
                SEL_ONE:   extOne_r   <= addr;
                SEL_TWO:   extTwo_r   <= addr;
                SEL_THREE: extThree_r <= addr;
            endcase
        end
    end

    // Latency fields
    logic [2:0] postedDelay;
    logic [2:0] columnAccessDelay;
    logic [3:0] readDelay;
    logic [3:0] writeDelay;

    assign postedDelay       = extOne_r[POSTED_HI:POSTED_LO]; // [R2]
    assign columnAccessDelay = baseCfg_r[CAS_HI:CAS_LO];
    assign readDelay         = {1'b0, postedDelay} + {1'b0, columnAccessDelay}; // [R4]
    assign writeDelay        = readDelay - 4'h1; // [R5]
    assign refreshFast       = extTwo_r[REFRESH_BIT_POS]; // [R7]

    // Column command pipe and tap selection
    logic                  colCmd;
    logic [PIPE_DEPTH-1:0] pipeValid;
    logic [PIPE_DEPTH-1:0] pipeWrite;

    assign colCmd = (cmd == CMD_READ) || (cmd == CMD_WRITE);

    ddrx_post_pipe u_pipe (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .inValid   (colCmd),
        .inWrite   (cmd == CMD_WRITE),
        .pipeValid (pipeValid),
        .pipeWrite (pipeWrite)
    );

    // Bit of the command that is d cycles old, zero meaning this cycle
    function automatic logic tapAt(input logic [3:0] d, input logic now,
                                   input logic [PIPE_DEPTH-1:0] vec);
        logic [3:0] idx;
        idx = d - 4'h1;
        tapAt = (d == 4'h0) ? now : vec[idx];
    endfunction

    logic tapIssue;
    logic tapIssueWr;
    logic tapRead;
    logic tapReadWr;
    logic tapWrite;
    logic tapWriteWr;

    assign tapIssue   = tapAt({1'b0, postedDelay}, colCmd, pipeValid); // [R3]
    assign tapIssueWr = tapAt({1'b0, postedDelay}, cmd == CMD_WRITE, pipeWrite);
    assign tapRead    = tapAt(readDelay, colCmd, pipeValid);
    assign tapReadWr  = tapAt(readDelay, cmd == CMD_WRITE, pipeWrite);
    assign tapWrite   = tapAt(writeDelay, colCmd, pipeValid);
    assign tapWriteWr = tapAt(writeDelay, cmd == CMD_WRITE, pipeWrite);

    // Registered timing strobes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            internalIssue   <= 1'b0;
            internalIsWrite <= 1'b0;
            readDataStart   <= 1'b0;
            writeDataExpect <= 1'b0;
        end else begin
            internalIssue   <= tapIssue; // [R3]
            internalIsWrite <= tapIssue && tapIssueWr;
            readDataStart   <= tapRead && !tapReadWr; // [R4]
            writeDataExpect <= tapWrite && tapWriteWr; // [R5]
        end
    end

    // Timers: power and clock gate waits, loop lock
    logic        waitStart;
    logic        waitDone;
    logic        lockStart;
    logic        lockDone;
    logic [15:0] waitLoad;
    logic [15:0] lockLoad;

    assign waitLoad = 16'(CKE_WAIT_CYC); // [R14] [R24]
    assign lockLoad = 16'(DLL_LOCK_CYC); // [R18]

    // Power wait runs from reset, then reloads for the clock gate wait
    ddrx_wait_timer #(
        .RESET_COUNT (16'(POWER_WAIT))
    ) u_waitTmr (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .start   (waitStart),
        .loadVal (waitLoad),
        .expired (waitDone)
    );

    // Loop lock count from the loop reset load
    ddrx_wait_timer u_lockTmr (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .start   (lockStart),
        .loadVal (lockLoad),
        .expired (lockDone)
    );

    // Load kinds by bank select
    logic loadBase;
    logic loadOne;
    logic loadTwo;
    logic loadThree;

    assign loadBase  = isLoad && (bankSel == SEL_BASE);
    assign loadOne   = isLoad && (bankSel == SEL_ONE);
    assign loadTwo   = isLoad && (bankSel == SEL_TWO);
    assign loadThree = isLoad && (bankSel == SEL_THREE);

    // Load gap and refresh counters
    logic [1:0] gapCnt_r;
    logic [1:0] gapCnt_nxt;
    logic [1:0] refCnt_r;
    logic [1:0] refCnt_nxt;
    logic       gapBusy;
    logic       refEnough;

    assign gapBusy    = (gapCnt_r != 2'h0);
    assign refEnough  = (refCnt_r >= 2'(MIN_REFRESHES)); // [R20]
    assign gapCnt_nxt = isLoad ? 2'(CFG_LOAD_GAP_CYC - 1) : // [R8]
                        (gapBusy ? gapCnt_r - 2'h1 : 2'h0);
    assign refCnt_nxt = (cmd == CMD_REFRESH && !refEnough) ? refCnt_r + 2'h1 : refCnt_r;

    // Init sequence tracker
    ddrx_state_t state_r;
    ddrx_state_t state_nxt;
    logic        stepOk;
    logic        seqAct;
    logic        baseRun;
    logic        calOk;

    assign seqAct    = (state_r != ST_POWER_WAIT) && (state_r != ST_DONE);
    assign baseRun   = loadBase && !addr[DLL_RESET_POS] && refEnough; // [R21]
    assign waitStart = (state_r == ST_POWER_WAIT) && clkGate && waitDone; // [R13]
    assign lockStart = (state_r == ST_DLL_RESET) && stepOk; // [R18]
    assign calOk     = (calField == CAL_DEFAULT) || (calField == CAL_EXIT); // [R1]

    // Next step of the sequence, stepOk marks a command in order
    always_comb begin
        state_nxt = state_r;
        stepOk    = 1'b0;
        unique case (state_r)
            ST_POWER_WAIT: begin
                if (waitStart) state_nxt = ST_CKE_WAIT;
            end
            ST_CKE_WAIT: begin
                stepOk = isPreAll; // [R14]
                if (isPreAll && waitDone) state_nxt = ST_LOAD_TWO;
            end
            ST_LOAD_TWO: begin
                stepOk = loadTwo; // [R15]
                if (stepOk) state_nxt = ST_LOAD_THREE;
            end
            ST_LOAD_THREE: begin
                stepOk = loadThree; // [R16]
                if (stepOk) state_nxt = ST_LOAD_ONE;
            end
            ST_LOAD_ONE: begin
                stepOk = loadOne && !addr[DLL_DISABLE_POS]; // [R17]
                if (stepOk) state_nxt = ST_DLL_RESET;
            end
            ST_DLL_RESET: begin
                stepOk = loadBase && addr[DLL_RESET_POS]; // [R18]
                if (stepOk) state_nxt = ST_PRE_ALL;
            end
            ST_PRE_ALL: begin
                stepOk = isPreAll; // [R20]
                if (stepOk) state_nxt = ST_REFRESH;
            end
            ST_REFRESH: begin
                stepOk = (cmd == CMD_REFRESH) || baseRun; // [R20] [R21]
                if (baseRun) state_nxt = ST_CAL_DEFAULT;
            end
            ST_CAL_DEFAULT: begin
                stepOk = loadOne && (calField == CAL_DEFAULT); // [R22]
                if (stepOk) state_nxt = ST_CAL_EXIT;
            end
            ST_CAL_EXIT: begin
                stepOk = loadOne && (calField == CAL_EXIT); // [R22]
                if (stepOk) state_nxt = ST_DONE;
            end
            ST_DONE: begin
                stepOk = 1'b1;
            end
        endcase
    end

    // Fault detection, flags stay set until reset
    logic             earlyErr;
    logic             rsvdErr;
    logic [ERR_W-1:0] errNow;
    logic [ERR_W-1:0] errFlags_r;

    assign earlyErr = ((state_r == ST_POWER_WAIT) && (notNop || (clkGate && !waitDone))) ||
                      ((state_r == ST_CKE_WAIT) && isPreAll && !waitDone); // [R13] [R14]
    assign rsvdErr  = isLoad && (bank_sel_two || (|addr[ADDR_W-1:TOP_VALID_POS+1]) || // [R10]
                      (loadOne && (addr[POSTED_HI:POSTED_LO] > POSTED_MAX)) || // [R6]
                      (loadTwo && (|addr[ADDR_W-1:REFRESH_BIT_POS+1])) || // [R7]
                      (loadTwo && (|addr[REFRESH_BIT_POS-1:0])) ||
                      (loadThree && (addr != CFG_RESET))); // [R11]

    always_comb begin
        errNow            = '0;
        errNow[ERR_SEQ]   = seqAct && notNop && !stepOk;
        errNow[ERR_EARLY] = earlyErr;
        errNow[ERR_CKE]   = seqAct && !clkGate; // [R12]
        errNow[ERR_ODT]   = (state_r != ST_DONE) && termination_ctrl_in; // [R19]
        errNow[ERR_RSVD]  = rsvdErr;
        errNow[ERR_GAP]   = gapBusy && notNop; // [R8]
        errNow[ERR_CAL]   = loadOne && !calOk; // [R1]
    end

    // APB: no wait states, read-only view, writes are ignored
    logic        apbSetup;
    logic        ofsValid;
    logic [31:0] rdMux;

    assign apbSetup = psel && !penable;
    assign pready   = psel && penable;
    assign pslverr  = pready && !ofsValid;

    always_comb begin
        ofsValid = 1'b1;
        rdMux    = 32'h0000_0000;
        case (paddr)
            OFS_ERR:   rdMux = 32'(errFlags_r);
            OFS_STATE: rdMux = 32'(state_r);
            OFS_ONE:   rdMux = 32'(extOne_r);
            OFS_TWO:   rdMux = 32'(extTwo_r);
            OFS_THREE: rdMux = 32'(extThree_r);
            OFS_BASE:  rdMux = 32'(baseCfg_r);
            default:   ofsValid = 1'b0;
        endcase
    end

    // Sequence state, counters, flags, ready and read data captured at setup
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= ST_POWER_WAIT;
            gapCnt_r    <= 2'h0;
            refCnt_r    <= 2'h0;
            errFlags_r  <= '0;
            deviceReady <= 1'b0;
            prdata      <= 32'h0000_0000;
        end else begin
            state_r     <= state_nxt;
            gapCnt_r    <= gapCnt_nxt;
            refCnt_r    <= refCnt_nxt;
            errFlags_r  <= errFlags_r | errNow;
            deviceReady <= (state_r == ST_DONE) && lockDone; // [R23]
            if (apbSetup) prdata <= rdMux;
        end
    end
endmodule

// File: ddrx_cfg_init_checker.sv
// Assertion checker for the configuration and init tracking block
`timescale 1ns/100ps
module ddrx_cfg_init_checker
    import ddrx_pkg::*;
(
    // Clock, reset and command pins
    input wire logic              mclk, rst_n,
    input wire logic              chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n,
    input wire logic              bank_sel0, bank_sel1,
    input wire logic [ADDR_W-1:0] addr,
    // Device outputs
    input wire logic              deviceReady, refreshFast, internalIssue, internalIsWrite,
    input wire logic              readDataStart, writeDataExpect
);
    // Command decode
    wire colCmd = !chipSel_n && rowStrobe_n && !colStrobe_n;
    wire loadCmd = !chipSel_n && !rowStrobe_n && !colStrobe_n && !writeEn_n;
    wire [1:0] bankSel = {bank_sel1, bank_sel0};
    wire loadTwo = loadCmd && bankSel == SEL_TWO;
    logic [2:0] postR, casR;
    logic [7:0] ageR;
    logic [15:0] dllR;
    logic wrR, dllSeenR;
    // Latency settings, age of last column command, lock count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            postR <= 3'h0;
            casR <= 3'h0;
            ageR <= 8'hff;
            dllR <= 16'h0000;
            wrR <= 1'b0;
            dllSeenR <= 1'b0;
        end else begin
            if (loadCmd && bankSel == SEL_ONE) postR <= addr[POSTED_HI:POSTED_LO];
            if (loadCmd && bankSel == SEL_BASE) casR <= addr[CAS_HI:CAS_LO];
            if (colCmd) wrR <= !writeEn_n;
            ageR <= colCmd ? 8'h00 : (ageR == 8'hff ? ageR : ageR + 8'h01);
            if (loadCmd && bankSel == SEL_BASE && addr[DLL_RESET_POS]) begin
                dllR <= 16'h0000;
                dllSeenR <= 1'b1;
            end else if (dllR != 16'hffff) dllR <= dllR + 16'h0001;
        end
    end
    AST_READ_DELAY: assert property (@(posedge mclk) disable iff (!rst_n)
        readDataStart |-> ageR == postR + casR) else $error("read data off time");
    AST_WRITE_DELAY: assert property (@(posedge mclk) disable iff (!rst_n)
        writeDataExpect |-> ageR + 8'd1 == postR + casR) else $error("write data off time");
    AST_ISSUE_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
        internalIssue && postR != 0 |-> ageR == postR) else $error("issue off time");
    AST_ISSUE_KIND: assert property (@(posedge mclk) disable iff (!rst_n)
        internalIssue && postR != 0 |-> internalIsWrite == wrR) else $error("issue kind");
    AST_CONFIG_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
        !$stable(refreshFast) |-> $past(loadTwo)) else $error("refresh bit changed");
    AST_READY_LOCK: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(deviceReady) |-> dllSeenR && dllR >= 16'd199) else $error("ready too soon");
    AST_READY_ORDER: assert property (@(posedge mclk) disable iff (!rst_n)
        deviceReady |-> dllSeenR) else $error("ready without lock");
endmodule
bind ddrx_cfg_init ddrx_cfg_init_checker u_chk (.mclk, .rst_n, .chipSel_n, .rowStrobe_n,
    .colStrobe_n, .writeEn_n, .bank_sel0, .bank_sel1, .addr, .deviceReady, .refreshFast,
    .internalIssue, .internalIsWrite, .readDataStart, .writeDataExpect);

// File: ddrx_ctrl_model.sv
// Memory controller model driving the command, bank and address pins
`timescale 1ns/100ps
module ddrx_ctrl_model
    import ddrx_pkg::*;
(
    // Clock
    input  wire logic      mclk,
    // Command pins
    output logic           clkGate, chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n,
    output logic           bank_sel0, bank_sel1, bank_sel_two, termination_ctrl_in,
    output logic [ADDR_W-1:0] addr
);
    localparam logic [3:0] C_LD = 4'h0, C_REF = 4'h1, C_PRE = 4'h2, C_ACT = 4'h3;
    localparam logic [3:0] C_WR = 4'h4, C_RD = 4'h5;
    // Idle pins at time zero
    initial begin
        clkGate = 1'b0;
        {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} = 4'h7;
        {bank_sel1, bank_sel0} = 2'h0;
        bank_sel_two = 1'b0;
        termination_ctrl_in = 1'b0;
        addr = 16'h0000;
    end
    // One command, then NOP with the address no longer held
    task automatic cmd(input logic [3:0] c, input logic [1:0] bs, input logic [15:0] a,
                       input int gap);
        @(posedge mclk);
        {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} <= c;
        {bank_sel1, bank_sel0} <= bs;
        addr <= a;
        @(posedge mclk);
        {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} <= 4'h7;
        addr <= ~a;
        repeat (gap) @(posedge mclk);
    endtask
    // Power-up sequence with chosen base and first-register settings
    task automatic init_seq(input int pw, input logic [15:0] base, input logic [15:0] one);
        repeat (pw) @(posedge mclk);
        clkGate <= 1'b1;
        repeat (CKE_WAIT_CYC) @(posedge mclk);
        cmd(C_PRE, 2'h0, 16'h0400, 4);
        cmd(C_LD, SEL_TWO, 16'h0080, CFG_LOAD_GAP_CYC);
        cmd(C_LD, SEL_THREE, 16'h0000, CFG_LOAD_GAP_CYC);
        cmd(C_LD, SEL_ONE, 16'h0000, CFG_LOAD_GAP_CYC);
        cmd(C_LD, SEL_BASE, base | 16'h0100, CFG_LOAD_GAP_CYC);
        cmd(C_PRE, 2'h0, 16'h0400, 4);
        repeat (MIN_REFRESHES) cmd(C_REF, 2'h0, 16'h0000, 4);
        cmd(C_LD, SEL_BASE, base, CFG_LOAD_GAP_CYC);
        cmd(C_LD, SEL_ONE, one | 16'h0380, CFG_LOAD_GAP_CYC);
        cmd(C_LD, SEL_ONE, one, CFG_LOAD_GAP_CYC);
    endtask
endmodule

// File: ddrx_pkg.sv
// Shared constants and types for the configuration and init tracking block
package ddrx_pkg;
    // Clock rate and waits converted to cycles, least times rounded up
    localparam int CLK_PERIOD_NS   = 5;
    localparam int POWER_WAIT_US   = 200;
    localparam int POWER_WAIT_CYC  = (POWER_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CKE_WAIT_NS     = 400;
    localparam int CKE_WAIT_CYC    = (CKE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLL_LOCK_CYC    = 200;
    localparam int CFG_LOAD_GAP_CYC = 2;
    localparam int MIN_REFRESHES   = 2;
    localparam int PIPE_DEPTH      = 16;

    // Address and bank field positions
    localparam int ADDR_W          = 16;
    localparam int DLL_DISABLE_POS = 0;
    localparam int POSTED_LO       = 3;
    localparam int POSTED_HI       = 5;
    localparam int CAS_LO          = 4;
    localparam int CAS_HI          = 6;
    localparam int REFRESH_BIT_POS = 7;
    localparam int DLL_RESET_POS   = 8;
    localparam int CAL_LO          = 7;
    localparam int CAL_HI          = 9;
    localparam int PRE_ALL_POS     = 10;
    localparam int TOP_VALID_POS   = 12;
    localparam logic [2:0] POSTED_MAX = 3'h6;
    localparam logic [2:0] CAL_DEFAULT = 3'h7;
    localparam logic [2:0] CAL_EXIT    = 3'h0;

    // Bank select codes for the configuration loads
    localparam logic [1:0] SEL_BASE  = 2'h0;
    localparam logic [1:0] SEL_ONE   = 2'h1;
    localparam logic [1:0] SEL_TWO   = 2'h2;
    localparam logic [1:0] SEL_THREE = 2'h3;

    // APB register byte offsets
    localparam logic [7:0] OFS_ERR   = 8'h00;
    localparam logic [7:0] OFS_STATE = 8'h04;
    localparam logic [7:0] OFS_ONE   = 8'h08;
    localparam logic [7:0] OFS_TWO   = 8'h0C;
    localparam logic [7:0] OFS_THREE = 8'h10;
    localparam logic [7:0] OFS_BASE  = 8'h14;

    // Error flag positions in the error register
    localparam int ERR_SEQ   = 0;
    localparam int ERR_EARLY = 1;
    localparam int ERR_CKE   = 2;
    localparam int ERR_ODT   = 3;
    localparam int ERR_RSVD  = 4;
    localparam int ERR_GAP   = 5;
    localparam int ERR_CAL   = 6;
    localparam int ERR_W     = 7;

    localparam logic [ADDR_W-1:0] CFG_RESET = 16'h0000;

    typedef enum logic [2:0] {
        CMD_NOP, CMD_LOAD, CMD_REFRESH, CMD_PRECHARGE, CMD_ACTIVATE, CMD_WRITE, CMD_READ
    } ddrx_cmd_t;

    typedef enum logic [3:0] {
        ST_POWER_WAIT, ST_CKE_WAIT, ST_LOAD_TWO, ST_LOAD_THREE, ST_LOAD_ONE,
        ST_DLL_RESET, ST_PRE_ALL, ST_REFRESH, ST_CAL_DEFAULT, ST_CAL_EXIT, ST_DONE
    } ddrx_state_t;
endpackage

// File: ddrx_post_pipe.sv
// Shift pipe that carries column commands for the posted and data delays
`timescale 1ns/100ps
module ddrx_post_pipe
    import ddrx_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // Command entering the pipe
    input  wire logic                  inValid,
    input  wire logic                  inWrite,
    // Stage contents, stage k is the command k+1 cycles old
    output logic [PIPE_DEPTH-1:0]      pipeValid,
    output logic [PIPE_DEPTH-1:0]      pipeWrite
);
    // Shift one stage per clock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pipeValid <= '0;
            pipeWrite <= '0;
        end else begin
            pipeValid <= {pipeValid[PIPE_DEPTH-2:0], inValid};
            pipeWrite <= {pipeWrite[PIPE_DEPTH-2:0], inWrite};
        end
    end
endmodule

// File: ddrx_wait_timer.sv
// Down counter that reports when a loaded wait has run out
`timescale 1ns/100ps
module ddrx_wait_timer
    import ddrx_pkg::*;
#(
    parameter logic [15:0] RESET_COUNT = 16'h0000
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Load and status
    input  wire logic        start,
    input  wire logic [15:0] loadVal,
    output logic             expired
);
    logic [15:0] count_r;

    // Reload on start, otherwise count down to zero and hold
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= RESET_COUNT;
        end else if (start) begin
            count_r <= loadVal;
        end else if (count_r != 16'h0000) begin
            count_r <= count_r - 16'h0001;
        end
    end

    assign expired = (count_r == 16'h0000);
endmodule

// File: tb_ddrx_cfg_init.sv
// Self-checking testbench for the configuration and init tracking block
`timescale 1ns/100ps
module tb_ddrx_cfg_init
    import ddrx_pkg::*;
;
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, rdv;
    logic errv;
    logic [2:0] pv [2] = '{3'h0, 3'h6};
    wire logic pready, pslverr, deviceReady, refreshFast, internalIssue, internalIsWrite;
    wire logic readDataStart, writeDataExpect, clkGate, chipSel_n, rowStrobe_n, colStrobe_n;
    wire logic writeEn_n, bank_sel0, bank_sel1, bank_sel_two, termination_ctrl_in;
    wire logic [31:0] prdata;
    wire logic [ADDR_W-1:0] addr;
    int fail_count = 0, check_count = 0, cyc = 0;
    always #2.5 mclk = ~mclk;
    ddrx_cfg_init #(.POWER_WAIT(20)) DUT (.mclk, .rst_n, .clkGate, .chipSel_n, .rowStrobe_n,
        .colStrobe_n, .writeEn_n, .bank_sel0, .bank_sel1, .bank_sel_two, .addr,
        .termination_ctrl_in, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .deviceReady, .refreshFast, .internalIssue, .internalIsWrite,
        .readDataStart, .writeDataExpect);
    ddrx_ctrl_model CTRL (.mclk, .clkGate, .chipSel_n, .rowStrobe_n, .colStrobe_n,
        .writeEn_n, .bank_sel0, .bank_sel1, .bank_sel_two, .addr, .termination_ctrl_in);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1 && ++n < 50);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic lat(input logic [3:0] c, input logic [31:0] exp);
        int n;
        CTRL.cmd(c, 2'h0, 16'h0000, 0);
        n = 0;
        @(negedge mclk);
        while ((c == CTRL.C_RD ? readDataStart : writeDataExpect) !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        check("data delay", 32'(n), exp);
    endtask
    task automatic test_init();
        CTRL.init_seq(22, 16'h0030, 16'h0018);
        check("early ready", deviceReady, 0);
        apb(1'b0, OFS_ERR, 0);
        check("fault flags", rdv, 0);
        repeat (DLL_LOCK_CYC) @(posedge mclk);
        check("ready", deviceReady, 1);
        check("refresh rate", refreshFast, 1);
        $display("init test done");
    endtask
    task automatic test_latency();
        foreach (pv[i]) begin
            CTRL.cmd(CTRL.C_LD, SEL_ONE, {10'h000, pv[i], 3'h0}, CFG_LOAD_GAP_CYC);
            CTRL.cmd(CTRL.C_ACT, 2'h0, 16'h0000, 6);
            lat(CTRL.C_RD, pv[i] + 3);
            lat(CTRL.C_WR, pv[i] + 2);
        end
        $display("latency test done");
    endtask
    task automatic test_regs();
        apb(1'b0, OFS_TWO, 0);
        check("second reg", rdv, 32'h0000_0080);
        apb(1'b1, OFS_TWO, 32'h0000_0000);
        apb(1'b0, OFS_TWO, 0);
        check("second reg kept", rdv, 32'h0000_0080);
        apb(1'b0, OFS_ONE, 0);
        check("first reg", rdv, 32'h0000_0030);
        check("good offset", errv, 0);
        apb(1'b0, 8'h3C, 0);
        check("bad offset", errv, 1);
        $display("register test done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Cycle ceiling against hangs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        test_init();
        test_latency();
        test_regs();
        wrap_up();
    end
endmodule
